//--- logic/dsd_decoder.sv
// dsd_decoder: data-space decode, address forming and access timing
// assumes a core that raises req_valid only while busy is low, and static wait states
//
// Notes on behaviour
// - program counter fifteen bits, 32K words
// - normal map: 32 regs, 64, 160, 4096
// - compat map: 32 regs, 64 io, 4000 sram
// - compat mode drops extended i/o region
// - short io form reaches only 64 locations
// - external sram follows internal sram
// - same operations reach external memory
// - strobes idle during internal accesses
// - external interface needs enable bit
// - external byte costs one extra cycle
// - external stack call/return three extra cycles
// - wait states add two, three, four
// - stack with waits adds five, seven, nine
// - internal sram access takes two cycles
// - displacement up to 63 from Y/Z
// - direct address reaches whole data space
// - regs 26-31 are pointers, auto update
// - stack pointer moves two per call/return
`timescale 1ns/1ps
`default_nettype none
module dsd_decoder import dsd_pkg::*; (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // configuration
    input  wire logic        compat_strap,
    input  wire logic        external_memory_enable,
    input  wire logic [1:0]  ext_wait_states,
    // cpu request
    input  wire logic        req_valid,
    input  wire dsd_op_t     req_op,
    input  wire dsd_amode_t  req_amode,
    input  wire logic [1:0]  req_ptr_sel,
    input  wire logic [15:0] req_addr,
    input  wire logic [5:0]  req_io_addr,
    input  wire logic [5:0]  req_disp,
    input  wire logic [7:0]  req_wdata,
    input  wire logic [14:0] req_pc,
    // cpu answer
    output logic             busy,
    output logic             done,
    output logic [7:0]       rd_data,
    output logic [PC_W-1:0]  program_counter,
    output var  dsd_region_t region,
    output logic             compat_mode,
    output logic [15:0]      stack_pointer,
    // i/o register port
    output logic [7:0]       io_addr,
    output logic             io_we,
    output logic             io_re,
    output logic [7:0]       io_wdata,
    input  wire logic [7:0]  io_rdata,
    // external sram
    output logic [15:0]      ext_addr,
    output logic [7:0]       ext_dout,
    output logic             ext_doe,
    input  wire logic [7:0]  ext_din,
    output logic             external_strobe_pin_a_n,
    output logic             external_strobe_pin_b_n
);

    typedef enum logic [1:0] {ST_IDLE, ST_NEXT, ST_XFER, ST_WAIT} dsd_state_t;

    logic [7:0] rf [RF_DEPTH];
    logic [7:0] sram [SRAM_DEPTH];

    dsd_state_t  state, next_state;
    dsd_region_t rg0, rg_a1, rg1, next_rg1, next_region, cur_rg;
    logic [4:0]  elapsed, next_elapsed, total, next_total, total_new, p_idx;
    logic [2:0]  xcnt, next_xcnt;
    logic [15:0] addr1, next_addr1, next_sp, next_ext_addr;
    logic [15:0] ptr, ptr_new, a0, a1, sp_new, cur_addr, soff;
    logic [7:0]  wdat1, next_wdat1, buf0, buf1, next_buf0, next_buf1, w0, w1, cur_w, rdv;
    logic [7:0]  next_rd_data, next_io_addr, next_io_wdata, next_ext_dout;
    logic [PC_W-1:0] next_pc;
    logic        two, next_two, xwr, next_xwr, xidx, next_xidx, io_idx, next_io_idx;
    logic        is_ret, next_is_ret, strap_taken, next_compat;
    logic        next_busy, next_done, next_io_we, next_io_re, next_ext_doe;
    logic        next_stb_a_n, next_stb_b_n;
    logic        is_ls, two_b, wr_op, ptr_upd, acc, any_x, cur_go, cur_wr, cur_idx, cur_ext;
    logic        rf_we, sram_we, ptr_we;
    logic [SRAM_AW-1:0] sram_idx;

    // request: address forming
    always_comb begin
        if (req_ptr_sel == 2'd2) begin
            p_idx = PTR_Z_IDX;
        end else if (req_ptr_sel == 2'd1 || req_amode == AM_DISP) begin
            p_idx = PTR_Y_IDX;
        end else begin
            p_idx = PTR_X_IDX;
        end
        ptr     = {rf[p_idx + 5'd1], rf[p_idx]};
        is_ls   = (req_op == OP_LOAD) || (req_op == OP_STORE);
        two_b   = (req_op == OP_CALL) || (req_op == OP_RET);
        wr_op   = (req_op == OP_STORE) || (req_op == OP_PUSH) || (req_op == OP_CALL);
        ptr_upd = is_ls && (req_amode == AM_PREDEC || req_amode == AM_POSTINC);
        ptr_new = (req_amode == AM_PREDEC) ? ptr - STK_STEP_B : ptr + STK_STEP_B;
        a0      = req_addr;
        a1      = 16'h0000;
        w0      = req_wdata;
        w1      = 8'h00;
        sp_new  = stack_pointer;
        case (req_op)
            OP_PUSH: begin
                sp_new = stack_pointer - STK_STEP_B;
                a0     = stack_pointer;
            end
            OP_POP: begin
                a0     = stack_pointer + STK_STEP_B;
                sp_new = a0;
            end
            OP_CALL: begin
                a0     = stack_pointer;
                a1     = stack_pointer - STK_STEP_B;
                w0     = req_pc[7:0];
                w1     = {1'b0, req_pc[14:8]};
                sp_new = stack_pointer - STK_STEP_RA;
            end
            OP_RET: begin
                a0     = stack_pointer + STK_STEP_B;
                a1     = stack_pointer + STK_STEP_RA;
                sp_new = a1;
            end
            default: begin
                case (req_amode)
                    AM_IO:                a0 = STDIO_BASE + {10'h000, req_io_addr};
                    AM_IND, AM_POSTINC:   a0 = ptr;
                    AM_PREDEC:            a0 = ptr_new;
                    AM_DISP:              a0 = ptr + {10'h000, req_disp};
                    default:              a0 = req_addr;
                endcase
            end
        endcase
    end

    dsd_region_decode u_dec0 (
        .addr   (a0),
        .compat (compat_mode),
        .region (rg0)
    );

    dsd_region_decode u_dec1 (
        .addr   (a1),
        .compat (compat_mode),
        .region (rg_a1)
    );

    // same load/store/stack operations go out when the region is external
    assign acc       = (state == ST_IDLE) && req_valid && strap_taken;
    assign any_x     = external_memory_enable && ((rg0 == RG_EXT) || (two_b && rg_a1 == RG_EXT));
    assign total_new = (two_b ? STACK_BASE_CYC : BYTE_BASE_CYC)
                     + (any_x ? dsd_extra_cyc(two_b, ext_wait_states) : 5'd0);
    assign cur_go    = acc || (state == ST_NEXT);
    assign cur_idx   = (state == ST_NEXT);
    assign cur_addr  = cur_idx ? addr1 : a0;
    assign cur_rg    = cur_idx ? rg1 : rg0;
    assign cur_w     = cur_idx ? wdat1 : w0;
    assign cur_wr    = cur_idx ? xwr : wr_op;
    assign cur_ext   = (cur_rg == RG_EXT) && external_memory_enable;
    assign soff      = cur_addr - (compat_mode ? SRAM_BASE_COMPAT : SRAM_BASE_NORM);
    assign sram_idx  = soff[SRAM_AW-1:0];

    // internal read value, i/o reads arrive one cycle later
    always_comb begin
        case (cur_rg)
            RG_REGFILE: rdv = rf[cur_addr[4:0]];
            RG_SRAM:    rdv = sram[sram_idx];
            RG_STDIO:   rdv = (cur_addr == SP_HI_ADDR) ? stack_pointer[15:8] : stack_pointer[7:0];
            default:    rdv = EXT_OFF_RDATA;
        endcase
    end

    // sequencer: next values
    always_comb begin
        next_state    = state;
        next_elapsed  = elapsed + 5'd1;
        next_total    = total;
        next_two      = two;
        next_xwr      = xwr;
        next_xidx     = xidx;
        next_xcnt     = xcnt;
        next_addr1    = addr1;
        next_rg1      = rg1;
        next_wdat1    = wdat1;
        next_is_ret   = is_ret;
        next_buf0     = buf0;
        next_buf1     = buf1;
        next_sp       = stack_pointer;
        next_io_idx   = io_idx;
        next_busy     = busy;
        next_done     = 1'b0;
        next_rd_data  = rd_data;
        next_pc       = program_counter;
        next_region   = region;
        next_ext_addr = ext_addr;
        next_ext_dout = ext_dout;
        next_ext_doe  = ext_doe;
        next_stb_a_n  = external_strobe_pin_a_n;
        next_stb_b_n  = external_strobe_pin_b_n;
        next_io_addr  = io_addr;
        next_io_we    = 1'b0;
        next_io_re    = 1'b0;
        next_io_wdata = io_wdata;
        next_compat   = strap_taken ? compat_mode : compat_strap;
        rf_we         = 1'b0;
        sram_we       = 1'b0;
        ptr_we        = 1'b0;
        if (io_re) begin
            if (io_idx) begin
                next_buf1 = io_rdata;
            end else begin
                next_buf0 = io_rdata;
            end
        end
        case (state)
            ST_IDLE: begin
                if (acc) begin
                    next_elapsed = 5'd1;
                    next_total   = total_new;
                    next_two     = two_b;
                    next_xwr     = wr_op;
                    next_addr1   = a1;
                    next_rg1     = rg_a1;
                    next_wdat1   = w1;
                    next_is_ret  = (req_op == OP_RET);
                    next_sp      = sp_new;
                    next_busy    = 1'b1;
                    next_region  = rg0;
                    ptr_we       = ptr_upd;
                    next_state   = two_b ? ST_NEXT : ST_WAIT;
                end
            end
            ST_NEXT: next_state = ST_WAIT;
            ST_XFER: begin
                if (xcnt == 3'd1) begin
                    next_stb_a_n = 1'b1;
                    next_stb_b_n = 1'b1;
                    next_ext_doe = 1'b0;
                    if (!xwr && xidx) begin
                        next_buf1 = ext_din;
                    end else if (!xwr) begin
                        next_buf0 = ext_din;
                    end
                    next_state = (two && !xidx) ? ST_NEXT : ST_WAIT;
                end else begin
                    next_xcnt = xcnt - 3'd1;
                end
            end
            ST_WAIT: begin
                // pad to the full cost so timing does not depend on byte order
                if (elapsed == total - 5'd1) begin
                    next_state = ST_IDLE;
                    next_done  = 1'b1;
                    next_busy  = 1'b0;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (cur_go && cur_ext) begin
            next_state    = ST_XFER;
            next_xcnt     = {1'b0, ext_wait_states} + 3'd1;
            next_xidx     = cur_idx;
            next_ext_addr = cur_addr;
            next_ext_dout = cur_w;
            next_ext_doe  = cur_wr;
            next_stb_a_n  = !cur_wr;
            next_stb_b_n  = cur_wr;
        end else if (cur_go && cur_rg != RG_EXT) begin
            // strobes are left untouched on every internal path
            if ((cur_rg == RG_STDIO && cur_addr != SP_LO_ADDR && cur_addr != SP_HI_ADDR)
                || cur_rg == RG_EXTIO) begin
                next_io_addr  = cur_addr[7:0];
                next_io_wdata = cur_w;
                next_io_we    = cur_wr;
                next_io_re    = !cur_wr;
                next_io_idx   = cur_idx;
            end else if (cur_wr) begin
                rf_we   = (cur_rg == RG_REGFILE);
                sram_we = (cur_rg == RG_SRAM);
                if (cur_addr == SP_LO_ADDR) begin
                    next_sp[7:0] = cur_w;
                end else if (cur_addr == SP_HI_ADDR) begin
                    next_sp[15:8] = cur_w;
                end
            end else if (cur_idx) begin
                next_buf1 = rdv;
            end else begin
                next_buf0 = rdv;
            end
        end else if (cur_go && !cur_wr) begin
            if (cur_idx) begin
                next_buf1 = rdv;
            end else begin
                next_buf0 = rdv;
            end
        end
        if (next_done) begin
            next_rd_data = next_buf0;
            if (is_ret) begin
                next_pc = {next_buf0[6:0], next_buf1};
            end
        end
    end

    // memories carry no reset
    always_ff @(posedge core_clk) begin
        if (rf_we) begin
            rf[cur_addr[4:0]] <= cur_w;
        end
        if (ptr_we) begin
            rf[p_idx]        <= ptr_new[7:0];
            rf[p_idx + 5'd1] <= ptr_new[15:8];
        end
        if (sram_we) begin
            sram[sram_idx] <= cur_w;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            elapsed <= 5'h00;
            total <= 5'h00;
            xcnt <= 3'h0;
            two <= 1'b0;
            xwr <= 1'b0;
            xidx <= 1'b0;
            addr1 <= 16'h0000;
            rg1 <= RG_REGFILE;
            wdat1 <= 8'h00;
            is_ret <= 1'b0;
            buf0 <= 8'h00;
            buf1 <= 8'h00;
            io_idx <= 1'b0;
            strap_taken <= 1'b0;
            compat_mode <= 1'b0;
            stack_pointer <= SP_RESET;
            busy <= 1'b0;
            done <= 1'b0;
            rd_data <= 8'h00;
            program_counter <= '0;
            region <= RG_REGFILE;
            io_addr <= 8'h00;
            io_we <= 1'b0;
            io_re <= 1'b0;
            io_wdata <= 8'h00;
            ext_addr <= 16'h0000;
            ext_dout <= 8'h00;
            ext_doe <= 1'b0;
            external_strobe_pin_a_n <= 1'b1;
            external_strobe_pin_b_n <= 1'b1;
        end else begin
            state <= next_state;
            elapsed <= next_elapsed;
            total <= next_total;
            xcnt <= next_xcnt;
            two <= next_two;
            xwr <= next_xwr;
            xidx <= next_xidx;
            addr1 <= next_addr1;
            rg1 <= next_rg1;
            wdat1 <= next_wdat1;
            is_ret <= next_is_ret;
            buf0 <= next_buf0;
            buf1 <= next_buf1;
            io_idx <= next_io_idx;
            strap_taken <= 1'b1;
            compat_mode <= next_compat;
            stack_pointer <= next_sp;
            busy <= next_busy;
            done <= next_done;
            rd_data <= next_rd_data;
            program_counter <= next_pc;
            region <= next_region;
            io_addr <= next_io_addr;
            io_we <= next_io_we;
            io_re <= next_io_re;
            io_wdata <= next_io_wdata;
            ext_addr <= next_ext_addr;
            ext_dout <= next_ext_dout;
            ext_doe <= next_ext_doe;
            external_strobe_pin_a_n <= next_stb_a_n;
            external_strobe_pin_b_n <= next_stb_b_n;
        end
    end

    default clocking dsd_cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_strobe_internal : assert property (
        (state != ST_XFER) |-> (external_strobe_pin_a_n && external_strobe_pin_b_n))
        else $error("external strobe active outside an external transfer");
    a_disabled_quiet : assert property (
        (acc && !external_memory_enable) |=> (state != ST_XFER) && (done || !busy || total <= STACK_BASE_CYC))
        else $error("external cycle started while external memory is disabled");
    a_int_byte_len : assert property (
        (acc && !two_b && !any_x) |=> !done ##1 done)
        else $error("internal byte access did not take two cycles");
    a_ext_byte_ws0 : assert property (
        (acc && !two_b && any_x && ext_wait_states == 2'd0) |-> ##3 done)
        else $error("external byte without waits not one cycle longer");
    a_ext_byte_ws3 : assert property (
        (acc && !two_b && any_x && ext_wait_states == 2'd3) |=> (!done)[*5] ##0 busy ##1 done)
        else $error("external byte with three waits not four cycles longer");
    a_ext_stack_ws0 : assert property (
        (acc && two_b && any_x && ext_wait_states == 2'd0) |-> ##7 done)
        else $error("external stack call not three cycles longer");
    a_ext_stack_ws2 : assert property (
        (acc && two_b && any_x && ext_wait_states == 2'd2) |-> ##11 done)
        else $error("external stack call with two waits not seven cycles longer");
    a_sp_call : assert property (
        (acc && req_op == OP_CALL) |=> (stack_pointer == $past(stack_pointer) - STK_STEP_RA))
        else $error("stack pointer not lowered by two on call");
    a_io_short : assert property (
        (acc && is_ls && req_amode == AM_IO) |-> (rg0 == RG_STDIO))
        else $error("short i/o form left standard i/o");
    a_compat_map : assert property (
        (acc && compat_mode) |-> (rg0 != RG_EXTIO))
        else $error("extended i/o decoded in compatibility map");

    c_ext_call : cover property (acc && req_op == OP_CALL && any_x ##7 done);
    c_compat_sram : cover property (acc && compat_mode && rg0 == RG_SRAM);
    c_io_read : cover property (io_re ##1 done);

endmodule : dsd_decoder
`default_nettype wire

//--- logic/dsd_pkg.sv
// dsd_pkg: map boundaries, timing counts and shared types of the data-space decoder
// assumes a 16-bit data address space and byte-wide data
package dsd_pkg;

    // data-space map
    localparam logic [15:0] STDIO_BASE       = 16'h0020;
    localparam logic [15:0] EXTIO_BASE       = 16'h0060;
    localparam logic [15:0] SRAM_BASE_NORM   = 16'h0100;
    localparam logic [15:0] SRAM_BASE_COMPAT = 16'h0060;
    localparam logic [15:0] EXT_BASE_NORM    = 16'h1100;
    localparam logic [15:0] EXT_BASE_COMPAT  = 16'h1000;
    localparam int          SRAM_DEPTH       = 4096;
    localparam int          SRAM_AW          = 12;
    localparam int          RF_DEPTH         = 32;
    localparam int          PC_W             = 15;

    // stack pointer bytes inside standard i/o
    localparam logic [15:0] SP_LO_ADDR  = 16'h005D;
    localparam logic [15:0] SP_HI_ADDR  = 16'h005E;
    localparam logic [15:0] SP_RESET    = 16'h0000;
    localparam logic [15:0] STK_STEP_B  = 16'h0001;
    localparam logic [15:0] STK_STEP_RA = 16'h0002;

    // pointer pairs in the register file
    localparam logic [4:0] PTR_X_IDX = 5'h1A;
    localparam logic [4:0] PTR_Y_IDX = 5'h1C;
    localparam logic [4:0] PTR_Z_IDX = 5'h1E;

    // timing in core_clk cycles
    localparam logic [4:0] BYTE_BASE_CYC   = 5'h02;
    localparam logic [4:0] STACK_BASE_CYC  = 5'h04;
    localparam logic [4:0] EXT_BYTE_EXTRA  = 5'h01;
    localparam logic [4:0] EXT_STACK_EXTRA = 5'h03;
    localparam logic [7:0] EXT_OFF_RDATA   = 8'hFF;

    typedef enum logic [2:0] {RG_REGFILE, RG_STDIO, RG_EXTIO, RG_SRAM, RG_EXT} dsd_region_t;
    typedef enum logic [2:0] {OP_LOAD, OP_STORE, OP_PUSH, OP_POP, OP_CALL, OP_RET} dsd_op_t;
    typedef enum logic [2:0] {AM_DIRECT, AM_IO, AM_IND, AM_PREDEC, AM_POSTINC, AM_DISP} dsd_amode_t;

    // extra cycles of an external access; two-byte moves pay per wait state twice
    function automatic logic [4:0] dsd_extra_cyc(input logic two, input logic [1:0] ws);
        if (two) begin
            return EXT_STACK_EXTRA + {2'b00, ws, 1'b0};
        end
        return EXT_BYTE_EXTRA + {3'b000, ws};
    endfunction : dsd_extra_cyc

endpackage : dsd_pkg

//--- logic/dsd_region_decode.sv
// dsd_region_decode: steers one data address to its target region
// assumes the map selection is stable while an address is decoded
`timescale 1ns/1ps
`default_nettype none
module dsd_region_decode import dsd_pkg::*; (
    // address in
    input  wire logic [15:0] addr,
    input  wire logic        compat,
    // target out
    output var  dsd_region_t region
);

    always_comb begin
        if (addr < STDIO_BASE) begin
            region = RG_REGFILE;
        end else if (addr < EXTIO_BASE) begin
            region = RG_STDIO;
        end else if (compat) begin
            // no extended i/o here, sram starts right after standard i/o
            region = (addr < EXT_BASE_COMPAT) ? RG_SRAM : RG_EXT;
        end else if (addr < SRAM_BASE_NORM) begin
            region = RG_EXTIO;
        end else begin
            region = (addr < EXT_BASE_NORM) ? RG_SRAM : RG_EXT;
        end
    end

endmodule : dsd_region_decode
`default_nettype wire

//--- tb/dsd_ext_sram.sv
// dsd_ext_sram: external sram model on the decoder's strobe pins
// assumes active-low strobes and an address held while a strobe is low
`timescale 1ns/1ps
`default_nettype none
module dsd_ext_sram (
    // bus from the decoder
    input  wire logic        core_clk,
    input  wire logic [15:0] ext_addr,
    input  wire logic [7:0]  ext_dout,
    input  wire logic        ext_doe,
    input  wire logic        wr_n,
    input  wire logic        rd_n,
    // data back
    output logic [7:0]       ext_din
);
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    always @(posedge core_clk) begin
        if (!wr_n && ext_doe) begin
            mem[ext_addr] <= ext_dout;
        end
        if (!rd_n) begin
            last <= mem[ext_addr];
        end
    end
    // released bus shows the inverse, so stale data never passes
    assign ext_din = rd_n ? ~last : mem[ext_addr];
endmodule : dsd_ext_sram
`default_nettype wire

//--- tb/dsd_decoder_tb.sv
// dsd_decoder_tb: self-checking bench of the data-space decoder
// assumes the external sram model and falling-edge stimulus
`timescale 1ns/1ps
`default_nettype none
module dsd_decoder_tb;
    import dsd_pkg::*;
    logic core_clk = 0, sys_rst = 1, strap = 0, ext_en = 0, req_valid = 0;
    logic [1:0] ws = 2'h0, psel = 2'h0;
    logic [5:0] io_a = 6'h00, disp = 6'h00;
    dsd_op_t req_op = OP_LOAD;
    dsd_amode_t amode = AM_DIRECT;
    logic [15:0] req_addr = 16'h0000, stack_pointer, ext_addr;
    logic [7:0] req_wdata = 8'h00, rd_data, ext_din, ext_dout, io_addr;
    logic [14:0] ret_in = 15'h0000, program_counter;
    logic busy, done, compat_mode, ext_doe, wr_n, rd_n;
    dsd_region_t region;
    int mismatches = 0, check_count = 0, cyc = 0;
    dsd_decoder dsd_decoder_i (.core_clk(core_clk), .sys_rst(sys_rst), .compat_strap(strap),
        .external_memory_enable(ext_en), .ext_wait_states(ws), .req_valid(req_valid), .req_op(req_op),
        .req_amode(amode), .req_ptr_sel(psel), .req_addr(req_addr), .req_io_addr(io_a),
        .req_disp(disp), .req_wdata(req_wdata), .req_pc(ret_in), .busy(busy), .done(done),
        .rd_data(rd_data), .program_counter(program_counter), .region(region),
        .compat_mode(compat_mode), .stack_pointer(stack_pointer), .io_addr(io_addr), .io_we(), .io_re(),
        .io_wdata(), .io_rdata(8'h96), .ext_addr(ext_addr), .ext_dout(ext_dout), .ext_doe(ext_doe),
        .ext_din(ext_din), .external_strobe_pin_a_n(wr_n), .external_strobe_pin_b_n(rd_n));
    dsd_ext_sram dsd_ext_sram_i (.core_clk(core_clk), .ext_addr(ext_addr), .ext_dout(ext_dout),
        .ext_doe(ext_doe), .wr_n(wr_n), .rd_n(rd_n), .ext_din(ext_din));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic rst(input logic s);
        sys_rst = 1;
        strap = s;
        repeat (6) @(negedge core_clk);
        sys_rst = 0;
        repeat (2) @(negedge core_clk);
    endtask : rst
    // one request; counts cycles to done and cycles with a strobe low
    task automatic req(input dsd_op_t op, input logic [15:0] a, input logic [7:0] wd, input int en, input int es);
        int n;
        int s;
        req_valid = 1;
        req_op = op;
        req_addr = a;
        req_wdata = wd;
        n = 1;
        s = 0;
        @(negedge core_clk);
        req_valid = 0;
        forever begin
            if (wr_n !== 1'b1 || rd_n !== 1'b1) s++;
            if (done === 1'b1 || n > 40) break;
            @(negedge core_clk);
            n++;
        end
        chk("cycles", n, en);
        chk("strobe cycles", s, es);
    endtask : req
    task automatic t_internal;
        rst(0);
        ext_en = 1;
        req(OP_STORE, 16'h10FF, 8'h5A, 2, 0);
        req(OP_LOAD, 16'h10FF, 8'h00, 2, 0);
        chk("rd_data", rd_data, 8'h5A);
        req(OP_LOAD, 16'h0060, 8'h00, 2, 0);
        chk("region", region, RG_EXTIO);
        chk("io read", rd_data, 8'h96);
        chk("io_addr", io_addr, 8'h60);
    endtask : t_internal
    task automatic t_external;
        for (int w = 0; w < 4; w++) begin
            ws = w[1:0];
            req(OP_STORE, 16'h1100 + w, 8'hA0 + w, 3 + w, 1 + w);
            req(OP_LOAD, 16'h1100 + w, 8'h00, 3 + w, 1 + w);
            chk("rd_data", rd_data, 8'hA0 + w);
            chk("region", region, RG_EXT);
        end
    endtask : t_external
    task automatic t_disabled;
        ext_en = 0;
        req(OP_STORE, 16'h3000, 8'h11, 2, 0);
        req(OP_LOAD, 16'h3000, 8'h00, 2, 0);
        chk("rd_data", rd_data, 8'hFF);
        ext_en = 1;
    endtask : t_disabled
    task automatic t_stack;
        for (int w = 0; w < 3; w++) begin
            ws = w[1:0];
            req(OP_STORE, 16'h005D, 8'h00, 2, 0);
            req(OP_STORE, 16'h005E, 8'h80, 2, 0);
            chk("stack_pointer", stack_pointer, 16'h8000);
            ret_in = 15'h1234 + w;
            req(OP_CALL, 16'h0000, 8'h00, 7 + 2 * w, 2 + 2 * w);
            chk("stack_pointer", stack_pointer, 16'h7FFE);
            chk("stacked byte", dsd_ext_sram_i.mem[16'h8000], 8'h34 + w);
            req(OP_RET, 16'h0000, 8'h00, 7 + 2 * w, 2 + 2 * w);
            chk("program_counter", program_counter, 15'h1234 + w);
            chk("stack_pointer", stack_pointer, 16'h8000);
        end
    endtask : t_stack
    task automatic t_modes;
        req(OP_STORE, 16'h001A, 8'h00, 2, 0);
        req(OP_STORE, 16'h001B, 8'h10, 2, 0);
        amode = AM_POSTINC;
        req(OP_STORE, 16'h0000, 8'h77, 2, 0);
        amode = AM_DIRECT;
        req(OP_LOAD, 16'h001A, 8'h00, 2, 0);
        chk("pointer x low", rd_data, 8'h01);
        req(OP_STORE, 16'h001C, 8'hC1, 2, 0);
        req(OP_STORE, 16'h001D, 8'h0F, 2, 0);
        req(OP_STORE, 16'h001E, 8'h01, 2, 0);
        req(OP_STORE, 16'h001F, 8'h10, 2, 0);
        amode = AM_DISP;
        disp = 6'h3F;
        req(OP_LOAD, 16'h0000, 8'h00, 2, 0);
        chk("displacement load", rd_data, 8'h77);
        amode = AM_PREDEC;
        psel = 2'h2;
        req(OP_LOAD, 16'h0000, 8'h00, 2, 0);
        chk("predecrement load", rd_data, 8'h77);
        amode = AM_IO;
        io_a = 6'h3E;
        req(OP_LOAD, 16'h0000, 8'h00, 2, 0);
        chk("short io load", rd_data, 8'h80);
        chk("region", region, RG_STDIO);
        amode = AM_DIRECT;
        psel = 2'h0;
    endtask : t_modes
    task automatic t_compat;
        ws = 2'h0;
        rst(1);
        chk("compat_mode", compat_mode, 1'b1);
        req(OP_LOAD, 16'h0060, 8'h00, 2, 0);
        chk("region", region, RG_SRAM);
        req(OP_STORE, 16'h0FFF, 8'h3C, 2, 0);
        req(OP_STORE, 16'h1000, 8'hC3, 3, 1);
        req(OP_LOAD, 16'h0FFF, 8'h00, 2, 0);
        chk("rd_data", rd_data, 8'h3C);
    endtask : t_compat
    task automatic test_done;
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    // hang guard well above the fewer than two hundred cycles the tests need
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            test_done();
        end
    end
    initial begin
        t_internal();
        t_external();
        t_disabled();
        t_stack();
        t_modes();
        t_compat();
        test_done();
    end
endmodule : dsd_decoder_tb
`default_nettype wire
